// [hvs_bias_regs.vh]
// Constants for the high-voltage bias sequencer: link commands, register map, levels.
`ifndef HVS_BIAS_REGS_VH
`define HVS_BIAS_REGS_VH

// System clock period in nanoseconds.
`define HVS_CLK_NS 5

// Serial command frame: opcode in the top four bits, argument below.
`define HVS_FRAME_W 16
`define HVS_OP_MSB 15
`define HVS_OP_LSB 12
`define HVS_ARG_MSB 11

// Opcodes from the mechanical controller.
`define HVS_OP_NOP 4'h0
`define HVS_OP_JOB_START 4'h1
`define HVS_OP_CHG_BETWEEN 4'h2
`define HVS_OP_CHG_PRINT 4'h3
`define HVS_OP_CHG_OFF 4'h4
`define HVS_OP_DEV_ON 4'h5
`define HVS_OP_DEV_OFF 4'h6
`define HVS_OP_DENSITY 4'h7
`define HVS_OP_TR_ON 4'h8
`define HVS_OP_TR_PRINT 4'h9
`define HVS_OP_TR_BETWEEN 4'hA
`define HVS_OP_ATTRACT_ON 4'hB
`define HVS_OP_DISCH_ON 4'hC
`define HVS_OP_DISCH_OFF 4'hD
`define HVS_OP_SEP_ON 4'hE
`define HVS_OP_ALL_OFF 4'hF

// Register word indexes.
`define HVS_ADDR_DEV_DELAY 2'h0
`define HVS_ADDR_ATTR_TIME 2'h1
`define HVS_ADDR_STATUS 2'h2
`define HVS_ADDR_JOB 2'h3

// Environment classes from temperature/humidity sensing.
`define HVS_ENV_NORMAL 2'h0
`define HVS_ENV_HIGH_HUM 2'h1
`define HVS_ENV_LOW_LOW 2'h2
`define HVS_ENV_EXTREME 2'h3

// Levels: fixed charge density, transfer and attraction tables.
`define HVS_CHG_DENSITY 8'h80
`define HVS_DEV_DENSITY_RST 8'h80
`define HVS_TR_BETWEEN 8'h20
`define HVS_TR_STEP 8'h10
`define HVS_TR_BASE_NORMAL 8'h60
`define HVS_TR_BASE_HUM 8'h50
`define HVS_TR_BASE_LOW 8'h80
`define HVS_TR_BASE_EXT 8'h90
`define HVS_ATR_NORMAL 8'h40
`define HVS_ATR_HUM 8'h30
`define HVS_ATR_LOW 8'h60
`define HVS_ATR_EXT 8'h70

// Discharge level codes; bit n low on the pin is select n asserted.
`define HVS_DIS_OFF 2'h0
`define HVS_DIS_LOW 2'h1
`define HVS_DIS_MID 2'h2
`define HVS_DIS_HIGH 2'h3

`endif

// [hvs_bias_sequencer.v]
// High-voltage bias sequencer driving the printer's bias supply enable and level lines.
// Behaviour
// - Bias outputs change on link commands, on the cartridge, panel, request and environment pins, and when the developing delay or attraction timer ends.
// - Charge DC and AC drives are active low; both high means charging off.
// - Charge DC select low for between bias, high for print bias.
// - During print bias AC current select high for low current, low for high.
// - Charge density level is held at one constant value.
// - Initial rotations use DC with between bias, then AC with print bias.
// - Between colors and pages AC drive is high, only DC stays on.
// - Developing DC drive goes low once charging is on and cartridge pressed.
// - Developing AC drive goes low a programmable delay after developing DC.
// - Developing drives only while pressed; both high before cartridge separates.
// - Developing density level follows controller density commands.
// - Transfer drive low at drum start; level switches between print and between.
// - Full-color print level steps up per later color and follows environment.
// - Between-colors transfer level is below the print level.
// - Full-color jobs drive attraction low before first color, level by environment.
// - Attraction drive returns high after a programmable contact interval.
// - Discharge selects: both high off, sel0 alone low, sel1 alone middle, both low high.
// - At paper separation discharge bias is applied, level from environment.
// - Separation DC drive is low during the print period.
// - Manual panel force on or off overrides the separation AC request.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "hvs_bias_regs.vh"

module hvs_bias_sequencer #(
  parameter DEV_DELAY_NS = 100000,
  parameter ATTR_TIME_NS = 50000000
) (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire link_clk_i,
  input wire link_data_i,
  input wire link_latch_i,
  input wire print_request_n_i,
  input wire [1:0] env_class_i,
  input wire cart_pressed_i,
  input wire sep_ac_request_n_i,
  input wire panel_force_i,
  input wire panel_force_on_i,
  input wire [1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  output reg [31:0] reg_rdata_o,
  output reg charge_dc_drive_n_o,
  output reg charge_ac_drive_n_o,
  output reg charge_dc_select_o,
  output reg charge_ac_current_select_o,
  output reg [7:0] charge_density_level_o,
  output reg develop_dc_drive_n_o,
  output reg develop_ac_drive_n_o,
  output reg [7:0] develop_density_level_o,
  output reg transfer_drive_n_o,
  output reg [7:0] transfer_level_o,
  output reg attract_drive_n_o,
  output reg [7:0] attract_level_o,
  output reg discharge_level_sel0_n_o,
  output reg discharge_level_sel1_n_o,
  output reg separation_dc_drive_n_o,
  output reg separation_ac_drive_n_o
);

  // Least times round up to whole cycles; the counters hold 24 bits.
  localparam DEV_DELAY_RAW = (DEV_DELAY_NS + `HVS_CLK_NS - 1) / `HVS_CLK_NS;
  localparam ATTR_TIME_RAW = (ATTR_TIME_NS + `HVS_CLK_NS - 1) / `HVS_CLK_NS;
  localparam [23:0] DEV_DELAY_CYC = DEV_DELAY_RAW[23:0];
  localparam [23:0] ATTR_TIME_CYC = ATTR_TIME_RAW[23:0];

  localparam CHG_OFF = 2'h0;
  localparam CHG_BETWEEN = 2'h1;
  localparam CHG_PRINT = 2'h2;

  localparam SYNC_N = 10;

  // Pin inputs pass two flip-flops; only stage two is read by logic.
  reg [SYNC_N-1:0] sync_a;
  reg [SYNC_N-1:0] sync_b;
  wire [SYNC_N-1:0] pin_raw;
  assign pin_raw = {panel_force_on_i, link_clk_i, link_data_i, link_latch_i, print_request_n_i,
    env_class_i, cart_pressed_i, sep_ac_request_n_i, panel_force_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi = gi + 1)
    begin : g_sync
      always @(posedge clk_sys_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire force_on = sync_b[9];
  wire lk_clk = sync_b[8];
  wire lk_data = sync_b[7];
  wire lk_latch = sync_b[6];
  wire prn_req_n = sync_b[5];
  wire [1:0] env = sync_b[4:3];
  wire pressed = sync_b[2];
  wire sep_req_n = sync_b[1];
  wire force_en = sync_b[0];

  // Serial receiver: shift on link clock rise, decode on latch rise.
  reg lk_clk_d;
  reg lk_latch_d;
  reg [`HVS_FRAME_W-1:0] shift;
  wire lk_rise = lk_clk & ~lk_clk_d;
  wire frame_done = lk_latch & ~lk_latch_d;
  wire [3:0] op = shift[`HVS_OP_MSB:`HVS_OP_LSB];
  wire [7:0] arg = shift[7:0];

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lk_clk_d <= 1'b0;
      lk_latch_d <= 1'b0;
      shift <= 16'h0000;
    end
    else
    begin
      lk_clk_d <= lk_clk;
      lk_latch_d <= lk_latch;
      if (lk_rise)
        shift <= {shift[`HVS_FRAME_W-2:0], lk_data};
    end
  end

  // One-cycle command strobes.
  wire cmd = frame_done;
  wire c_job = cmd && op == `HVS_OP_JOB_START;
  wire c_off = cmd && op == `HVS_OP_ALL_OFF;

  // Software registers dev_delay and attr_time, and the job flags.
  reg [23:0] dev_delay;
  reg [23:0] attr_time;
  reg full_color;
  reg job_seen;

  // Environment tables.
  wire [7:0] tr_base_lvl = (env == `HVS_ENV_NORMAL) ? `HVS_TR_BASE_NORMAL :
    (env == `HVS_ENV_HIGH_HUM) ? `HVS_TR_BASE_HUM :
    (env == `HVS_ENV_LOW_LOW) ? `HVS_TR_BASE_LOW : `HVS_TR_BASE_EXT;
  wire [7:0] atr_env_lvl = (env == `HVS_ENV_NORMAL) ? `HVS_ATR_NORMAL :
    (env == `HVS_ENV_HIGH_HUM) ? `HVS_ATR_HUM :
    (env == `HVS_ENV_LOW_LOW) ? `HVS_ATR_LOW : `HVS_ATR_EXT;
  wire [1:0] dis_env_code = (env == `HVS_ENV_NORMAL) ? `HVS_DIS_LOW :
    (env == `HVS_ENV_HIGH_HUM) ? `HVS_DIS_MID : `HVS_DIS_HIGH;

  // Mono jobs never step; colour index only counts in full-color mode.
  wire [1:0] color_idx = full_color ? arg[1:0] : 2'h0;
  wire [7:0] tr_print = tr_base_lvl + {2'h0, color_idx, 4'h0};

  // Primary charging state.
  reg [1:0] chg_state;
  reg [1:0] next_chg_state;
  always @*
  begin
    next_chg_state = chg_state;
    if (c_off || (cmd && op == `HVS_OP_CHG_OFF))
      next_chg_state = CHG_OFF;
    else if (cmd && op == `HVS_OP_CHG_BETWEEN)
      next_chg_state = CHG_BETWEEN;
    else if (cmd && op == `HVS_OP_CHG_PRINT)
      next_chg_state = CHG_PRINT;
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      chg_state <= CHG_OFF;
      charge_dc_drive_n_o <= 1'b1;
      charge_ac_drive_n_o <= 1'b1;
      charge_dc_select_o <= 1'b1;
      charge_ac_current_select_o <= 1'b1;
      charge_density_level_o <= `HVS_CHG_DENSITY;
    end
    else
    begin
      chg_state <= next_chg_state;
      charge_density_level_o <= `HVS_CHG_DENSITY;
      case (next_chg_state)
        CHG_BETWEEN:
        begin
          charge_dc_drive_n_o <= 1'b0;
          charge_dc_select_o <= 1'b0;
          charge_ac_drive_n_o <= 1'b1;
          charge_ac_current_select_o <= 1'b1;
        end
        CHG_PRINT:
        begin
          charge_dc_drive_n_o <= 1'b0;
          charge_dc_select_o <= 1'b1;
          charge_ac_drive_n_o <= 1'b0;
          // Low-temperature air needs the higher AC current.
          charge_ac_current_select_o <= (env == `HVS_ENV_LOW_LOW ||
            env == `HVS_ENV_EXTREME) ? 1'b0 : 1'b1;
        end
        default:
        begin
          charge_dc_drive_n_o <= 1'b1;
          charge_ac_drive_n_o <= 1'b1;
          charge_dc_select_o <= 1'b1;
          charge_ac_current_select_o <= 1'b1;
        end
      endcase
    end
  end

  // Developing bias: DC first, AC after the programmed delay.
  reg dev_req;
  reg [23:0] dev_cnt;
  wire chg_on = chg_state != CHG_OFF;
  wire dev_allowed = dev_req && pressed && chg_on;
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dev_req <= 1'b0;
      dev_cnt <= 24'h000000;
      develop_dc_drive_n_o <= 1'b1;
      develop_ac_drive_n_o <= 1'b1;
      develop_density_level_o <= `HVS_DEV_DENSITY_RST;
    end
    else
    begin
      if (c_off || (cmd && op == `HVS_OP_DEV_OFF))
        dev_req <= 1'b0;
      else if (cmd && op == `HVS_OP_DEV_ON)
        dev_req <= 1'b1;
      if (cmd && op == `HVS_OP_DENSITY)
        develop_density_level_o <= arg;
      if (!dev_allowed)
      begin
        develop_dc_drive_n_o <= 1'b1;
        develop_ac_drive_n_o <= 1'b1;
        dev_cnt <= 24'h000000;
      end
      else
      begin
        develop_dc_drive_n_o <= 1'b0;
        if (dev_cnt >= dev_delay)
          develop_ac_drive_n_o <= 1'b0;
        else
          dev_cnt <= dev_cnt + 24'h000001;
      end
    end
  end

  // Transfer and attraction bias.
  reg [23:0] attr_cnt;
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      transfer_drive_n_o <= 1'b1;
      transfer_level_o <= `HVS_TR_BETWEEN;
      attract_drive_n_o <= 1'b1;
      attract_level_o <= `HVS_ATR_NORMAL;
      attr_cnt <= 24'h000000;
    end
    else if (c_off)
    begin
      transfer_drive_n_o <= 1'b1;
      transfer_level_o <= `HVS_TR_BETWEEN;
      attract_drive_n_o <= 1'b1;
      attr_cnt <= 24'h000000;
    end
    else
    begin
      if (cmd && op == `HVS_OP_TR_ON)
      begin
        transfer_drive_n_o <= 1'b0;
        transfer_level_o <= `HVS_TR_BETWEEN;
      end
      else if (cmd && op == `HVS_OP_TR_PRINT)
        transfer_level_o <= tr_print;
      else if (cmd && op == `HVS_OP_TR_BETWEEN)
        transfer_level_o <= `HVS_TR_BETWEEN;
      if (cmd && op == `HVS_OP_ATTRACT_ON && full_color)
      begin
        attract_drive_n_o <= 1'b0;
        attract_level_o <= atr_env_lvl;
        attr_cnt <= 24'h000000;
      end
      else if (!attract_drive_n_o)
      begin
        if (attr_cnt >= attr_time)
          attract_drive_n_o <= 1'b1;
        else
          attr_cnt <= attr_cnt + 24'h000001;
      end
    end
  end

  // Discharge and separation bias.
  reg [1:0] dis_code;
  reg sep_on;
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dis_code <= `HVS_DIS_OFF;
      sep_on <= 1'b0;
      discharge_level_sel0_n_o <= 1'b1;
      discharge_level_sel1_n_o <= 1'b1;
      separation_dc_drive_n_o <= 1'b1;
      separation_ac_drive_n_o <= 1'b1;
    end
    else
    begin
      if (c_off || (cmd && op == `HVS_OP_DISCH_OFF))
        dis_code <= `HVS_DIS_OFF;
      else if (cmd && op == `HVS_OP_DISCH_ON)
        dis_code <= dis_env_code;
      // The separation argument bit 0 selects on or off.
      if (c_off)
        sep_on <= 1'b0;
      else if (cmd && op == `HVS_OP_SEP_ON)
        sep_on <= arg[0];
      discharge_level_sel0_n_o <= ~dis_code[0];
      discharge_level_sel1_n_o <= ~dis_code[1];
      separation_dc_drive_n_o <= ~sep_on;
      // AC is superimposed on DC only, so it needs the DC drive on.
      if (!sep_on)
        separation_ac_drive_n_o <= 1'b1;
      else if (force_en)
        separation_ac_drive_n_o <= ~force_on;
      else
        separation_ac_drive_n_o <= sep_req_n;
    end
  end

  // Job flags: full-color mode and the print request seen at job start.
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      full_color <= 1'b0;
      job_seen <= 1'b0;
    end
    else if (c_job)
    begin
      full_color <= arg[0];
      job_seen <= ~prn_req_n;
    end
    else if (c_off)
      job_seen <= 1'b0;
  end

  // Register port: writes take effect at once, reads answer next cycle.
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dev_delay <= DEV_DELAY_CYC;
      attr_time <= ATTR_TIME_CYC;
      reg_rdata_o <= 32'h00000000;
    end
    else
    begin
      if (reg_write_i && reg_addr_i == `HVS_ADDR_DEV_DELAY)
        dev_delay <= reg_wdata_i[23:0];
      if (reg_write_i && reg_addr_i == `HVS_ADDR_ATTR_TIME)
        attr_time <= reg_wdata_i[23:0];
      reg_rdata_o <= 32'h00000000;
      if (reg_read_i)
      begin
        case (reg_addr_i)
          `HVS_ADDR_DEV_DELAY: reg_rdata_o <= {8'h00, dev_delay};
          `HVS_ADDR_ATTR_TIME: reg_rdata_o <= {8'h00, attr_time};
          `HVS_ADDR_STATUS: reg_rdata_o <= {16'h0000, chg_state, dis_code,
            separation_ac_drive_n_o, separation_dc_drive_n_o, attract_drive_n_o,
            transfer_drive_n_o, develop_ac_drive_n_o, develop_dc_drive_n_o,
            charge_ac_current_select_o, charge_dc_select_o, charge_ac_drive_n_o,
            charge_dc_drive_n_o, pressed, prn_req_n};
          `HVS_ADDR_JOB: reg_rdata_o <= {16'h0000, transfer_level_o, 4'h0, env,
            job_seen, full_color};
          default: reg_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// [hvs_bias_sva.sv]
// Concurrent checks on the pins of the bias sequencer.
`timescale 1ns/1ps
`include "hvs_bias_regs.vh"
module hvs_bias_sva (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire cart_pressed_i,
  input wire panel_force_i,
  input wire panel_force_on_i,
  input wire charge_dc_drive_n_o,
  input wire charge_ac_drive_n_o,
  input wire charge_dc_select_o,
  input wire [7:0] charge_density_level_o,
  input wire develop_dc_drive_n_o,
  input wire develop_ac_drive_n_o,
  input wire transfer_drive_n_o,
  input wire attract_drive_n_o,
  input wire discharge_level_sel0_n_o,
  input wire discharge_level_sel1_n_o,
  input wire separation_dc_drive_n_o,
  input wire separation_ac_drive_n_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  wire all_off = &{charge_dc_drive_n_o, charge_ac_drive_n_o, develop_dc_drive_n_o,
    develop_ac_drive_n_o, transfer_drive_n_o, attract_drive_n_o, discharge_level_sel0_n_o,
    discharge_level_sel1_n_o, separation_dc_drive_n_o, separation_ac_drive_n_o};
  sequence s_dev_dc_on;
    $fell(develop_dc_drive_n_o);
  endsequence
  sequence s_dev_ac_waits;
    develop_ac_drive_n_o [*8];
  endsequence
  property p_reset_off;
    $rose(resetn_i) |-> all_off;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("bias line on after reset");
  property p_chg_fixed;
    charge_density_level_o == `HVS_CHG_DENSITY;
  endproperty
  a_chg_fixed: assert property (p_chg_fixed) else $error("charge level moved");
  property p_ac_print;
    !charge_ac_drive_n_o |-> !charge_dc_drive_n_o && charge_dc_select_o;
  endproperty
  a_ac_print: assert property (p_ac_print) else $error("charge AC without print DC");
  property p_dev_ac_lags;
    s_dev_dc_on |-> s_dev_ac_waits;
  endproperty
  a_dev_ac_lags: assert property (p_dev_ac_lags) else $error("developing AC too early");
  property p_dev_ac_dc;
    !develop_ac_drive_n_o |-> !develop_dc_drive_n_o;
  endproperty
  a_dev_ac_dc: assert property (p_dev_ac_dc) else $error("developing AC without DC");
  property p_dev_press;
    (!cart_pressed_i) [*4] |-> develop_dc_drive_n_o && develop_ac_drive_n_o;
  endproperty
  a_dev_press: assert property (p_dev_press) else $error("developing on while apart");
  property p_attr_holds;
    $fell(attract_drive_n_o) |=> (!attract_drive_n_o) [*8];
  endproperty
  a_attr_holds: assert property (p_attr_holds) else $error("attraction cut short");
  property p_sep_ac_dc;
    !separation_ac_drive_n_o |-> !separation_dc_drive_n_o;
  endproperty
  a_sep_ac_dc: assert property (p_sep_ac_dc) else $error("separation AC without DC");
  property p_panel_off;
    (panel_force_i && !panel_force_on_i) [*4] |-> separation_ac_drive_n_o;
  endproperty
  a_panel_off: assert property (p_panel_off) else $error("panel off not obeyed");
endmodule
bind hvs_bias_sequencer hvs_bias_sva i_sva (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .cart_pressed_i(cart_pressed_i), .panel_force_i(panel_force_i),
  .panel_force_on_i(panel_force_on_i), .charge_dc_drive_n_o(charge_dc_drive_n_o),
  .charge_ac_drive_n_o(charge_ac_drive_n_o), .charge_dc_select_o(charge_dc_select_o),
  .charge_density_level_o(charge_density_level_o), .develop_dc_drive_n_o(develop_dc_drive_n_o),
  .develop_ac_drive_n_o(develop_ac_drive_n_o), .transfer_drive_n_o(transfer_drive_n_o),
  .attract_drive_n_o(attract_drive_n_o), .discharge_level_sel0_n_o(discharge_level_sel0_n_o),
  .discharge_level_sel1_n_o(discharge_level_sel1_n_o),
  .separation_dc_drive_n_o(separation_dc_drive_n_o),
  .separation_ac_drive_n_o(separation_ac_drive_n_o));

// [hvs_mech_model.sv]
// Behavioural mechanical controller sending command frames and the separation AC request.
`timescale 1ns/1ps
`include "hvs_bias_regs.vh"
module hvs_mech_model (
  input wire logic clk_sys_i,
  input wire logic print_request_n_i,
  input wire logic [1:0] env_class_i,
  output logic link_clk_o,
  output logic link_data_o,
  output logic link_latch_o,
  output logic sep_ac_request_n_o
);
  initial
  begin
    link_clk_o = 1'b0;
    link_data_o = 1'b0;
    link_latch_o = 1'b0;
    sep_ac_request_n_o = 1'b1;
  end
  always @(posedge clk_sys_i)
    sep_ac_request_n_o <= (env_class_i != `HVS_ENV_LOW_LOW);
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Each link clock and latch level lasts three system cycles, each data bit six; the receiver accepts levels of one cycle.
  task automatic send(input logic [15:0] frame);
    int i;
    if (frame[15:12] == `HVS_OP_JOB_START)
      wait (print_request_n_i == 1'b0);
    @(posedge clk_sys_i);
    for (i = 15; i >= 0; i--)
    begin
      link_data_o <= frame[i];
      hold(3);
      link_clk_o <= 1'b1;
      hold(3);
      link_clk_o <= 1'b0;
    end
    link_latch_o <= 1'b1;
    // The data line has no pull, so it must not keep showing the last bit.
    link_data_o <= ~frame[0];
    hold(3);
    link_latch_o <= 1'b0;
    hold(3);
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the bias sequencer and its controller model.
`timescale 1ns/1ps
`include "hvs_bias_regs.vh"
module tb;
  typedef struct {int due; int sel; logic [31:0] exp; logic [31:0] mask;} hvs_note_t;
  localparam int DEV_NS = 100000;
  localparam int ATR_NS = 50000000;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic print_request_n_i = 1'b1;
  logic [1:0] env_class_i = 2'h0;
  logic cart_pressed_i = 1'b0;
  logic panel_force_i = 1'b0;
  logic panel_force_on_i = 1'b0;
  logic [1:0] reg_addr_i = 2'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic link_clk, link_data, link_latch, sep_req_n;
  wire [31:0] rdata;
  wire [7:0] chg_lvl, dev_lvl, tr_lvl, atr_lvl;
  wire [11:0] drv;
  hvs_note_t notes[$];
  hvs_note_t n;
  int cyc = 0;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] rnd = 32'h00014933;
  logic [1:0] env;
  logic [7:0] tr_base[4] = '{`HVS_TR_BASE_NORMAL, `HVS_TR_BASE_HUM, `HVS_TR_BASE_LOW,
    `HVS_TR_BASE_EXT};
  logic [7:0] atr_of[4] = '{`HVS_ATR_NORMAL, `HVS_ATR_HUM, `HVS_ATR_LOW, `HVS_ATR_EXT};
  string names[6] = '{"rdata", "drives", "chg_level", "dev_level", "tr_level", "atr_level"};
  hvs_bias_sequencer #(.DEV_DELAY_NS(DEV_NS), .ATTR_TIME_NS(ATR_NS)) i_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link_clk_i(link_clk), .link_data_i(link_data),
    .link_latch_i(link_latch), .print_request_n_i(print_request_n_i),
    .env_class_i(env_class_i), .cart_pressed_i(cart_pressed_i), .sep_ac_request_n_i(sep_req_n),
    .panel_force_i(panel_force_i), .panel_force_on_i(panel_force_on_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(rdata), .charge_dc_drive_n_o(drv[11]),
    .charge_ac_drive_n_o(drv[10]), .charge_dc_select_o(drv[9]),
    .charge_ac_current_select_o(drv[8]), .charge_density_level_o(chg_lvl),
    .develop_dc_drive_n_o(drv[7]), .develop_ac_drive_n_o(drv[6]),
    .develop_density_level_o(dev_lvl), .transfer_drive_n_o(drv[5]), .transfer_level_o(tr_lvl),
    .attract_drive_n_o(drv[4]), .attract_level_o(atr_lvl), .discharge_level_sel0_n_o(drv[3]),
    .discharge_level_sel1_n_o(drv[2]), .separation_dc_drive_n_o(drv[1]),
    .separation_ac_drive_n_o(drv[0]));
  hvs_mech_model i_mc (.clk_sys_i(clk_sys_i), .print_request_n_i(print_request_n_i),
    .env_class_i(env_class_i), .link_clk_o(link_clk), .link_data_o(link_data),
    .link_latch_o(link_latch), .sep_ac_request_n_o(sep_req_n));
  always #2.5 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] observe(input int sel);
    case (sel)
      0: return rdata;
      1: return {20'h0, drv};
      2: return {24'h0, chg_lvl};
      3: return {24'h0, dev_lvl};
      4: return {24'h0, tr_lvl};
      default: return {24'h0, atr_lvl};
    endcase
  endfunction
  task automatic want(input int sel, input logic [31:0] exp, input logic [31:0] mask,
    input int lag);
    notes.push_back('{cyc + lag, sel, exp, mask});
  endtask
  task automatic want_drv(input logic [11:0] exp, input logic [11:0] mask, input int lag);
    want(1, {20'h0, exp}, {20'h0, mask}, lag);
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_write_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so the note is due two counts on.
  task automatic reg_rd(input logic [1:0] a, input logic [31:0] exp, input logic [31:0] mask);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    want(0, exp, mask, 2);
    @(posedge clk_sys_i);
    reg_read_i <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [7:0] arg);
    i_mc.send({op, 4'h0, arg});
  endtask
  task automatic give_verdict;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc >= 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  always @(negedge clk_sys_i)
    while (notes.size() > 0 && notes[0].due <= cyc)
    begin
      n = notes.pop_front();
      checks++;
      if ((observe(n.sel) & n.mask) !== (n.exp & n.mask))
      begin
        n_errors++;
        $display("[FAIL] %s expected %h seen %h", names[n.sel], n.exp & n.mask,
          observe(n.sel) & n.mask);
      end
    end
  initial
  begin
    int c, e, k;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    want_drv(12'hFFF, 12'hFFF, 1);
    want(2, `HVS_CHG_DENSITY, 32'hFF, 1);
    want(3, `HVS_DEV_DENSITY_RST, 32'hFF, 1);
    want(4, `HVS_TR_BETWEEN, 32'hFF, 1);
    reg_rd(2'h0, DEV_NS / `HVS_CLK_NS, 32'hFFFFFFFF);
    reg_rd(2'h1, ATR_NS / `HVS_CLK_NS, 32'hFFFFFFFF);
    reg_wr(2'h0, 32'hFF00000A);
    reg_wr(2'h1, 32'h0000000A);
    reg_wr(2'h3, 32'hFFFFFFFF);
    reg_rd(2'h0, 32'h0000000A, 32'hFFFFFFFF);
    reg_rd(2'h1, 32'h0000000A, 32'hFFFFFFFF);
    reg_rd(2'h2, 32'h00000FFD, 32'h00003FFF);
    reg_rd(2'h3, {16'h0, `HVS_TR_BETWEEN, 8'h00}, 32'hFFFFFFFF);
    rnd = lfsr_next(rnd);
    env = rnd[1:0];
    env_class_i <= env;
    print_request_n_i <= 1'b0;
    cmd(`HVS_OP_JOB_START, 8'h01);
    cmd(`HVS_OP_CHG_BETWEEN, 8'h00);
    want_drv(12'h400, 12'hE00, 1);
    cmd(`HVS_OP_CHG_PRINT, 8'h00);
    want_drv({3'b001, env < 2'h2, 8'h00}, 12'hF00, 1);
    cmd(`HVS_OP_TR_ON, 8'h00);
    want_drv(12'h000, 12'h020, 1);
    for (c = 0; c < 4; c++)
    begin
      cmd(`HVS_OP_TR_PRINT, 8'(c));
      want(4, tr_base[env] + `HVS_TR_STEP * 8'(c), 32'hFF, 1);
      cmd(`HVS_OP_TR_BETWEEN, 8'h00);
      want(4, `HVS_TR_BETWEEN, 32'hFF, 1);
    end
    cmd(`HVS_OP_ATTRACT_ON, 8'h00);
    want_drv(12'h000, 12'h010, 1);
    want(5, atr_of[env], 32'hFF, 1);
    want_drv(12'h010, 12'h010, 14);
    cart_pressed_i <= 1'b1;
    cmd(`HVS_OP_DEV_ON, 8'h00);
    want_drv(12'h040, 12'h0C0, 1);
    want_drv(12'h000, 12'h0C0, 14);
    rnd = lfsr_next(rnd);
    cmd(`HVS_OP_DENSITY, rnd[15:8]);
    want(3, rnd[15:8], 32'hFF, 1);
    cmd(`HVS_OP_CHG_BETWEEN, 8'h00);
    want_drv(12'h400, 12'hE00, 1);
    cart_pressed_i <= 1'b0;
    want_drv(12'h0C0, 12'h0C0, 8);
    for (e = 0; e < 4; e++)
    begin
      env_class_i <= 2'(e);
      cmd(`HVS_OP_DISCH_ON, 8'h00);
      want_drv({8'h00, e == 1, e == 0, 2'b00}, 12'h00C, 1);
    end
    cmd(`HVS_OP_DISCH_OFF, 8'h00);
    want_drv(12'h00C, 12'h00C, 1);
    // Environment and panel pins pass a synchroniser, so they settle during the frame.
    for (k = 0; k < 6; k++)
    begin
      env_class_i <= (k < 3) ? 2'h0 : 2'h2;
      panel_force_i <= (k % 3 != 0);
      panel_force_on_i <= (k % 3 == 2);
      cmd(`HVS_OP_SEP_ON, 8'h01);
      want_drv({11'h0, (k % 3 == 0) ? (k < 3) : (k % 3 == 1)}, 12'h003, 1);
    end
    panel_force_i <= 1'b0;
    cmd(`HVS_OP_SEP_ON, 8'h00);
    want_drv(12'h003, 12'h003, 1);
    cmd(`HVS_OP_JOB_START, 8'h00);
    cmd(`HVS_OP_ATTRACT_ON, 8'h00);
    want_drv(12'h010, 12'h010, 1);
    cmd(`HVS_OP_TR_PRINT, 8'h02);
    want(4, tr_base[2], 32'hFF, 1);
    cmd(`HVS_OP_ALL_OFF, 8'h00);
    want_drv(12'hFFF, 12'hCFF, 1);
    cmd(`HVS_OP_TR_ON, 8'h00);
    resetn_i <= 1'b0;
    want_drv(12'hFFF, 12'hFFF, 2);
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    want_drv(12'hFFF, 12'hFFF, 2);
    reg_rd(2'h0, DEV_NS / `HVS_CLK_NS, 32'hFFFFFFFF);
    repeat (3) @(posedge clk_sys_i);
    give_verdict();
  end
endmodule
